// File: common/mfp_regs.vh
`ifndef MFP_REGS_VH
`define MFP_REGS_VH

// Clock
`define MFP_CLK_PERIOD_NS 10

// Soft current limit: percent = base + step * code
`define MFP_SOFT_BASE_PCT 8'h26
`define MFP_SOFT_STEP_PCT 8'h02

// Hard overcurrent glitch filter: (code + 1) * step
`define MFP_FILT_STEP_NS 500
`define MFP_FILT_STEP_CYC ((`MFP_FILT_STEP_NS + `MFP_CLK_PERIOD_NS - 1) / `MFP_CLK_PERIOD_NS)

// Hard overcurrent hold time: (code + 1) * unit
`define MFP_HOLD_UNIT_MS 100
`define MFP_HOLD_UNIT_CYC ((`MFP_HOLD_UNIT_MS * 1000000) / `MFP_CLK_PERIOD_NS)

// Fault mask bit positions
`define MFP_MASK_OVM 0
`define MFP_MASK_UVM 1
`define MFP_MASK_HOC 2
`define MFP_MASK_PMF 3
`define MFP_MASK_W 4

// Synchronised input positions
`define MFP_S_OV 0
`define MFP_S_UV_LO 1
`define MFP_S_UV_HI 2
`define MFP_S_H150 3
`define MFP_S_H200 4
`define MFP_S_THERM 5
`define MFP_S_BUV 6
`define MFP_S_LUV 7
`define MFP_S_XRST 8
`define MFP_S_W 9

// Reset values
`define MFP_FLAG_RST 1'b0
`define MFP_GATE_RST 1'b1
`define MFP_PIN_RST 1'b1

`endif

// File: verilog/mfp_glitch_filter.v
`timescale 1ns/10ps
`default_nettype none
`include "mfp_regs.vh"

module mfp_glitch_filter (
    input wire clk,
    input wire arst_n,
    input wire raw,
    input wire [1:0] filt_code,
    output reg pass
);

    localparam integer STEP_FULL = `MFP_FILT_STEP_CYC;
    localparam [7:0] STEP = STEP_FULL[7:0];

    reg [7:0] cnt;
    wire [7:0] limit;

    // Longest setting is 200 cycles, so eight bits suffice
    assign limit = ({6'h00, filt_code} + 8'h01) * STEP;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 8'h00;
            pass <= 1'b0;
        end else if (!raw) begin
            // Any drop restarts the qualification window
            cnt <= 8'h00; // RL12
            pass <= 1'b0;
        end else if (cnt >= limit - 8'h01) begin
            pass <= 1'b1; // RL12
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

endmodule // mfp_glitch_filter

`default_nettype wire

// File: verilog/mfp_top.v
// Functional notes
// RL1: Overvoltage sets summary, high flags; stop-on-fault disables
// RL2: Undervoltage sets summary, low flags; stop-on-fault disables
// RL3: One bit selects lower or higher undervoltage level
// RL4: Soft overcurrent sets flags and disables transistors
// RL5: Stop-on-fault latches overcurrent shutdown until restart
// RL6: Without stop-on-fault, soft trip resumes below limit
// RL7: Soft limit is thirty-eight plus twice code percent
// RL8: Code zero turns soft detection fully off
// RL9: Hard trip disables first, then sets flags
// RL10: Hard trip turns transistors off within ten microseconds
// RL11: One bit selects hard threshold 150 or 200
// RL12: Hard comparator filter rejects pulses below set time
// RL13: Without stop-on-fault, hold off, resume, repeat until stop
// RL14: Hold time is one plus code times 100ms
// RL15: Overtemperature pulls fault pin low, sets module flag
// RL16: Pin releases on recovery; module flag stays set
// RL17: Bootstrap undervoltage disables, no fault pin, auto restart
// RL18: Logic undervoltage sets module flag, pulls pin low
// RL19: Soft latch released by reset pin, read, power-on
// RL20: Masked fault sets no flag and no pin
// RL21: Every comparator input passes two-stage synchroniser
`timescale 1ns/10ps
`default_nettype none
`include "mfp_regs.vh"

module mfp_top #(
    parameter [31:0] HOLD_UNIT_CYCLES = `MFP_HOLD_UNIT_CYC
) (
    input wire clk,
    input wire arst_n,
    input wire supply_high_cmp,
    input wire supply_low_cmp_lo,
    input wire supply_low_cmp_hi,
    input wire hard_cmp_150,
    input wire hard_cmp_200,
    input wire thermal_cmp,
    input wire boot_uv_cmp,
    input wire logic_uv_cmp,
    input wire external_reset_pin_n,
    input wire [23:0] phase_current,
    input wire stop_on_fault,
    input wire supply_low_level_select,
    input wire hard_threshold_select,
    input wire [4:0] soft_limit_code,
    input wire [1:0] glitch_filter_time,
    input wire [3:0] hold_time_code,
    input wire [`MFP_MASK_W-1:0] fault_mask,
    input wire stop_cmd,
    input wire serial_read_done,
    output reg gate_disable,
    output reg fault_summary_flag,
    output reg supply_high_flag,
    output reg supply_low_flag,
    output reg soft_overcurrent_flag,
    output reg hard_overcurrent_flag,
    output reg power_module_fault_flag,
    output reg fault_pin_n,
    output reg hold_active,
    output reg shutdown_latched
);

    localparam [1:0] ST_RUN = 2'b00;
    localparam [1:0] ST_HOLD = 2'b01;
    localparam [1:0] ST_LATCH = 2'b10;

    // Comparator synchronisers
    wire [`MFP_S_W-1:0] async_in;
    reg [`MFP_S_W-1:0] sync1;
    reg [`MFP_S_W-1:0] sync2;

    // Reset pin is inverted ahead of the first stage so all stages reset to zero
    assign async_in = {~external_reset_pin_n, logic_uv_cmp, boot_uv_cmp, thermal_cmp,
                       hard_cmp_200, hard_cmp_150, supply_low_cmp_hi, supply_low_cmp_lo,
                       supply_high_cmp};

    genvar gi;
    generate
        for (gi = 0; gi < `MFP_S_W; gi = gi + 1) begin : g_sync
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= async_in[gi]; // RL21
                    sync2[gi] <= sync1[gi]; // RL21
                end
            end
        end
    endgenerate

    wire s_ov;
    wire s_uv_lo;
    wire s_uv_hi;
    wire s_h150;
    wire s_h200;
    wire s_therm;
    wire s_buv;
    wire s_luv;
    wire s_xrst;

    assign s_ov = sync2[`MFP_S_OV];
    assign s_uv_lo = sync2[`MFP_S_UV_LO];
    assign s_uv_hi = sync2[`MFP_S_UV_HI];
    assign s_h150 = sync2[`MFP_S_H150];
    assign s_h200 = sync2[`MFP_S_H200];
    assign s_therm = sync2[`MFP_S_THERM];
    assign s_buv = sync2[`MFP_S_BUV];
    assign s_luv = sync2[`MFP_S_LUV];
    assign s_xrst = sync2[`MFP_S_XRST];

    // Supply voltage faults
    wire ov_act;
    wire uv_raw;
    wire uv_act;

    assign ov_act = s_ov & ~fault_mask[`MFP_MASK_OVM]; // RL20
    assign uv_raw = supply_low_level_select ? s_uv_hi : s_uv_lo; // RL3
    assign uv_act = uv_raw & ~fault_mask[`MFP_MASK_UVM]; // RL20

    // Soft overcurrent: one comparison per phase
    wire [7:0] soft_limit;
    wire soft_enable;
    wire [2:0] phase_over;
    wire soft_act;

    assign soft_limit = `MFP_SOFT_BASE_PCT + {3'h0, soft_limit_code} * `MFP_SOFT_STEP_PCT; // RL7
    assign soft_enable = (soft_limit_code != 5'h00); // RL8

    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_phase
            assign phase_over[gi] = (phase_current[gi*8 +: 8] > soft_limit);
        end
    endgenerate

    assign soft_act = soft_enable & (|phase_over); // RL8

    // Hard overcurrent: threshold select, then glitch filter
    wire hard_raw;
    wire hard_pass;
    wire hard_act;

    assign hard_raw = hard_threshold_select ? s_h200 : s_h150; // RL11

    // Filter plus synchroniser stays far below the turn-off budget
    mfp_glitch_filter u_filter (
        .clk(clk),
        .arst_n(arst_n),
        .raw(hard_raw),
        .filt_code(glitch_filter_time),
        .pass(hard_pass)
    );

    assign hard_act = hard_pass & ~fault_mask[`MFP_MASK_HOC]; // RL20

    // Power module fault: gate-driver overtemperature or logic undervoltage
    wire pmf_act;

    assign pmf_act = (s_therm | s_luv) & ~fault_mask[`MFP_MASK_PMF]; // RL20

    // Restart events release the latch and clear the flags
    wire restart_evt;

    assign restart_evt = s_xrst | serial_read_done; // RL19

    // Hold time
    wire [31:0] hold_total;

    assign hold_total = ({28'h0000000, hold_time_code} + 32'h00000001) * HOLD_UNIT_CYCLES; // RL14

    // Shutdown state machine
    reg [1:0] state;
    reg [1:0] next_state;
    reg [31:0] hold_cnt;
    reg [31:0] next_hold_cnt;

    always @* begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        case (state)
            ST_RUN: begin
                if (stop_on_fault && (hard_act || soft_act)) begin
                    next_state = ST_LATCH; // RL5
                end else if (hard_act) begin
                    next_state = ST_HOLD; // RL13
                    next_hold_cnt = hold_total - 32'h00000001;
                end
            end
            ST_HOLD: begin
                if (stop_cmd) begin
                    // Host stop ends the retry loop; hold off until a restart
                    next_state = ST_LATCH; // RL13
                end else if (hold_cnt == 32'h00000000) begin
                    next_state = ST_RUN; // RL13
                end else begin
                    next_hold_cnt = hold_cnt - 32'h00000001;
                end
            end
            ST_LATCH: begin
                if (restart_evt) begin
                    next_state = ST_RUN; // RL19
                end
            end
            default: begin
                next_state = ST_LATCH;
            end
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_RUN;
            hold_cnt <= 32'h00000000;
        end else begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
        end
    end

    // Gate disable is computed from the same cycle's trip, one cycle ahead of the hard trip flags
    reg next_gate_disable;

    always @* begin
        next_gate_disable = 1'b0;
        if (next_state != ST_RUN) begin
            next_gate_disable = 1'b1; // RL5
        end
        if (hard_act) begin
            next_gate_disable = 1'b1; // RL10
        end
        if (soft_act) begin
            next_gate_disable = 1'b1; // RL4
        end
        if (stop_on_fault && (ov_act || uv_act)) begin
            next_gate_disable = 1'b1; // RL1
        end
        if (stop_on_fault && pmf_act) begin
            next_gate_disable = 1'b1; // RL15
        end
        if (s_buv) begin
            // Bootstrap undervoltage is not maskable and never reaches the pin
            next_gate_disable = 1'b1; // RL17
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_disable <= `MFP_GATE_RST;
        end else begin
            gate_disable <= next_gate_disable; // RL6
        end
    end

    // Hard flag lags the gate by one cycle
    reg hard_act_d;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hard_act_d <= 1'b0;
        end else begin
            hard_act_d <= hard_act; // RL9
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    wire sum_set;

    assign sum_set = ov_act | uv_act | soft_act | hard_act_d;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_summary_flag <= `MFP_FLAG_RST;
            supply_high_flag <= `MFP_FLAG_RST;
            supply_low_flag <= `MFP_FLAG_RST;
            soft_overcurrent_flag <= `MFP_FLAG_RST;
            hard_overcurrent_flag <= `MFP_FLAG_RST;
            power_module_fault_flag <= `MFP_FLAG_RST;
        end else begin
            fault_summary_flag <= sum_set | (fault_summary_flag & ~restart_evt); // RL1
            supply_high_flag <= ov_act | (supply_high_flag & ~restart_evt); // RL1
            supply_low_flag <= uv_act | (supply_low_flag & ~restart_evt); // RL2
            soft_overcurrent_flag <= soft_act | (soft_overcurrent_flag & ~restart_evt); // RL4
            hard_overcurrent_flag <= hard_act_d | (hard_overcurrent_flag & ~restart_evt); // RL9
            power_module_fault_flag <= pmf_act | (power_module_fault_flag & ~restart_evt); // RL16
        end
    end

    // Fault pin follows the live condition, unlike the flag
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_pin_n <= `MFP_PIN_RST;
        end else begin
            fault_pin_n <= ~pmf_act; // RL18
        end
    end

    // State readback
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_active <= 1'b0;
            shutdown_latched <= 1'b0;
        end else begin
            hold_active <= (next_state == ST_HOLD);
            shutdown_latched <= (next_state == ST_LATCH);
        end
    end

endmodule // mfp_top

`default_nettype wire

// File: tb/mfp_cmp_model.sv
`timescale 1ns/10ps
`default_nettype none
module mfp_cmp_model (
    input wire logic [11:0] vm_mv,
    input wire logic [8:0] peak_pct,
    output logic ov,
    output logic uv_lo,
    output logic uv_hi,
    output logic h150,
    output logic h200
);
    // Ideal levels, no hysteresis, so edge cases land exactly on the limit
    assign ov = vm_mv >= 12'h4D8;
    assign uv_lo = vm_mv <= 12'h12C;
    assign uv_hi = vm_mv <= 12'h258;
    assign h150 = peak_pct > 9'h096;
    assign h200 = peak_pct > 9'h0C8;
endmodule // mfp_cmp_model
`default_nettype wire

// File: tb/mfp_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module mfp_monitor #(
    parameter [31:0] HOLD_UNIT_CYCLES = 32'h14
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic supply_high_cmp,
    input wire logic supply_low_cmp_lo,
    input wire logic supply_low_cmp_hi,
    input wire logic hard_cmp_150,
    input wire logic hard_cmp_200,
    input wire logic thermal_cmp,
    input wire logic boot_uv_cmp,
    input wire logic logic_uv_cmp,
    input wire logic external_reset_pin_n,
    input wire logic [23:0] phase_current,
    input wire logic stop_on_fault,
    input wire logic supply_low_level_select,
    input wire logic hard_threshold_select,
    input wire logic [4:0] soft_limit_code,
    input wire logic [1:0] glitch_filter_time,
    input wire logic [3:0] hold_time_code,
    input wire logic [3:0] fault_mask,
    input wire logic stop_cmd,
    input wire logic serial_read_done,
    input wire logic gate_disable,
    input wire logic fault_summary_flag,
    input wire logic supply_high_flag,
    input wire logic supply_low_flag,
    input wire logic soft_overcurrent_flag,
    input wire logic hard_overcurrent_flag,
    input wire logic fault_pin_n,
    input wire logic hold_active,
    input wire logic shutdown_latched
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [7:0] lim;
    logic soft_hit;
    logic hard_sel;
    logic [15:0] hlim;
    logic [15:0] hcnt;
    logic [31:0] hold_cnt;
    assign lim = 8'h26 + {2'h0, soft_limit_code, 1'b0};
    assign soft_hit = soft_limit_code != 5'h00 && (phase_current[7:0] > lim || phase_current[15:8] > lim
        || phase_current[23:16] > lim);
    assign hard_sel = (hard_threshold_select ? hard_cmp_200 : hard_cmp_150) && !fault_mask[2];
    // Counts raw comparator time, so sync and filter latency show up in hlim
    assign hlim = 16'h0032 * ({14'h0, glitch_filter_time} + 16'h0001) + 16'h0004;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hcnt <= 16'h0000;
            hold_cnt <= 32'h0;
        end else begin
            hcnt <= hard_sel ? hcnt + 16'h0001 : 16'h0000;
            hold_cnt <= hold_active ? hold_cnt + 32'h1 : 32'h0;
        end
    end
    sequence s_hard_entry;
        $rose(hold_active);
    endsequence
    a_soft_trip: assert property (soft_hit |=> gate_disable && soft_overcurrent_flag && fault_summary_flag)
        else $error("soft trip missed");
    a_hard_fast: assert property (hcnt == hlim |-> gate_disable)
        else $error("hard trip late");
    a_hard_filter: assert property (s_hard_entry |-> hcnt + 16'h0003 >= hlim)
        else $error("short hard pulse passed");
    a_hard_order: assert property ($rose(hard_overcurrent_flag) |-> $past(gate_disable) && fault_summary_flag)
        else $error("hard flag before gate");
    a_hold_len: assert property ($fell(hold_active) && !$past(stop_cmd)
        |-> hold_cnt == ({28'h0, hold_time_code} + 32'h1) * HOLD_UNIT_CYCLES)
        else $error("hold length wrong");
    a_latch_keep: assert property (shutdown_latched && !serial_read_done && external_reset_pin_n
        && $past(external_reset_pin_n) && $past(external_reset_pin_n, 2) |=> gate_disable)
        else $error("latch released");
    a_ov_flags: assert property ((supply_high_cmp && !fault_mask[0])[*4]
        |=> supply_high_flag && fault_summary_flag && (gate_disable || !stop_on_fault))
        else $error("overvoltage missed");
    a_uv_select: assert property (((supply_low_level_select ? supply_low_cmp_hi : supply_low_cmp_lo)
        && !fault_mask[1])[*4] |=> supply_low_flag && fault_summary_flag)
        else $error("undervoltage missed");
    a_pin_cause: assert property (!fault_pin_n |-> !fault_mask[3]
        && ($past(thermal_cmp || logic_uv_cmp, 3) || $past(thermal_cmp || logic_uv_cmp, 4)))
        else $error("fault pin low without cause");
    a_boot_off: assert property (boot_uv_cmp[*4] |=> gate_disable)
        else $error("bootstrap trip missed");
endmodule // mfp_monitor
bind mfp_top mfp_monitor #(.HOLD_UNIT_CYCLES(HOLD_UNIT_CYCLES)) mon_u (
    .clk, .arst_n, .supply_high_cmp, .supply_low_cmp_lo, .supply_low_cmp_hi, .hard_cmp_150, .hard_cmp_200,
    .thermal_cmp, .boot_uv_cmp, .logic_uv_cmp, .external_reset_pin_n, .phase_current, .stop_on_fault,
    .supply_low_level_select, .hard_threshold_select, .soft_limit_code, .glitch_filter_time, .hold_time_code,
    .fault_mask, .stop_cmd, .serial_read_done, .gate_disable, .fault_summary_flag, .supply_high_flag,
    .supply_low_flag, .soft_overcurrent_flag, .hard_overcurrent_flag, .fault_pin_n, .hold_active,
    .shutdown_latched
);
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 0;
    logic arst_n = 0;
    logic [11:0] vm = 12'h3E8;
    logic [7:0] ph = 8'h00;
    logic [8:0] pk = 9'h000;
    logic [23:0] phase_current;
    logic thermal_cmp = 0, boot_uv_cmp = 0, logic_uv_cmp = 0, external_reset_pin_n = 1, stop_on_fault = 0;
    logic supply_low_level_select = 0, hard_threshold_select = 0, stop_cmd = 0, serial_read_done = 0;
    logic [4:0] soft_limit_code = 5'h15;
    logic [1:0] glitch_filter_time = 2'h0;
    logic [3:0] hold_time_code = 4'h1;
    logic [3:0] fault_mask = 4'h0;
    logic supply_high_cmp, supply_low_cmp_lo, supply_low_cmp_hi, hard_cmp_150, hard_cmp_200, gate_disable;
    logic fault_summary_flag, supply_high_flag, supply_low_flag, soft_overcurrent_flag, hard_overcurrent_flag;
    logic power_module_fault_flag, fault_pin_n, hold_active, shutdown_latched;
    logic [7:0] st;
    int num_errors = 0;
    int n_tests = 0;
    int k;
    assign phase_current = {8'h00, ph, 8'h00};
    assign st = {gate_disable, fault_summary_flag, supply_high_flag, supply_low_flag, soft_overcurrent_flag,
        hard_overcurrent_flag, power_module_fault_flag, fault_pin_n};
    always #5 clk = ~clk;
    mfp_cmp_model cmp_u (.vm_mv(vm), .peak_pct(pk), .ov(supply_high_cmp), .uv_lo(supply_low_cmp_lo),
        .uv_hi(supply_low_cmp_hi), .h150(hard_cmp_150), .h200(hard_cmp_200));
    mfp_top #(.HOLD_UNIT_CYCLES(32'h14)) dut_u (
        .clk, .arst_n, .supply_high_cmp, .supply_low_cmp_lo, .supply_low_cmp_hi, .hard_cmp_150, .hard_cmp_200,
        .thermal_cmp, .boot_uv_cmp, .logic_uv_cmp, .external_reset_pin_n, .phase_current, .stop_on_fault,
        .supply_low_level_select, .hard_threshold_select, .soft_limit_code, .glitch_filter_time, .hold_time_code,
        .fault_mask, .stop_cmd, .serial_read_done, .gate_disable, .fault_summary_flag, .supply_high_flag,
        .supply_low_flag, .soft_overcurrent_flag, .hard_overcurrent_flag, .power_module_fault_flag, .fault_pin_n,
        .hold_active, .shutdown_latched
    );
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic go(input logic [11:0] v, input logic [7:0] p, input logic [8:0] q, input int n, input logic [7:0] e);
        vm = v;
        ph = p;
        pk = q;
        tick(n);
        chk(st, e);
    endtask
    task automatic clr;
        serial_read_done = 1;
        tick(1);
        serial_read_done = 0;
        tick(2);
    endtask
    task automatic wait_gate;
        for (k = 0; k < 1000 && gate_disable !== 1'b1; k++) tick(1);
        if (k == 1000) begin
            num_errors++;
            give_verdict;
        end
    endtask
    task give_verdict;
        if (num_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        tick(8);
        arst_n = 1;
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h01);
        go(12'h4D8, 8'h00, 9'h000, 4, 8'h61);
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h61);
        clr;
        fault_mask = 4'h1;
        go(12'h4D8, 8'h00, 9'h000, 4, 8'h01);
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h01);
        fault_mask = 4'h0;
        stop_on_fault = 1;
        go(12'h4D8, 8'h00, 9'h000, 4, 8'hE1);
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h61);
        clr;
        stop_on_fault = 0;
        for (int i = 0; i < 2; i++) begin
            supply_low_level_select = i[0];
            go(12'h1F4, 8'h00, 9'h000, 4, i ? 8'h51 : 8'h01);
            go(12'h3E8, 8'h00, 9'h000, 4, i ? 8'h51 : 8'h01);
            clr;
        end
        go(12'h3E8, 8'h50, 9'h000, 2, 8'h01);
        go(12'h3E8, 8'h51, 9'h000, 2, 8'hC9);
        go(12'h3E8, 8'h00, 9'h000, 2, 8'h49);
        clr;
        stop_on_fault = 1;
        go(12'h3E8, 8'h51, 9'h000, 2, 8'hC9);
        go(12'h3E8, 8'h00, 9'h000, 8, 8'hC9);
        chk({7'h0, shutdown_latched}, 8'h01);
        external_reset_pin_n = 0;
        tick(4);
        external_reset_pin_n = 1;
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h01);
        stop_on_fault = 0;
        soft_limit_code = 5'h00;
        go(12'h3E8, 8'hFF, 9'h000, 4, 8'h01);
        go(12'h3E8, 8'h00, 9'h000, 2, 8'h01);
        soft_limit_code = 5'h15;
        go(12'h3E8, 8'h00, 9'h097, 48, 8'h01);
        hard_threshold_select = 1;
        go(12'h3E8, 8'h00, 9'h000, 8, 8'h01);
        go(12'h3E8, 8'h00, 9'h097, 100, 8'h01);
        hard_threshold_select = 0;
        wait_gate;
        chk({7'h0, k > 49 && k < 60}, 8'h01);
        chk(st, 8'h81);
        tick(1);
        chk(st, 8'hC5);
        chk({6'h0, hold_active, shutdown_latched}, 8'h02);
        go(12'h3E8, 8'h00, 9'h000, 45, 8'h45);
        pk = 9'h097;
        wait_gate;
        stop_cmd = 1;
        tick(1);
        stop_cmd = 0;
        go(12'h3E8, 8'h00, 9'h000, 60, 8'hC5);
        chk({6'h0, hold_active, shutdown_latched}, 8'h01);
        clr;
        go(12'h3E8, 8'h00, 9'h000, 2, 8'h01);
        thermal_cmp = 1;
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h02);
        thermal_cmp = 0;
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h03);
        clr;
        stop_on_fault = 1;
        logic_uv_cmp = 1;
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h82);
        logic_uv_cmp = 0;
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h03);
        clr;
        fault_mask = 4'h8;
        thermal_cmp = 1;
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h01);
        thermal_cmp = 0;
        // Unmask only after the synchronised comparator has dropped
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h01);
        fault_mask = 4'h0;
        boot_uv_cmp = 1;
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h81);
        boot_uv_cmp = 0;
        go(12'h3E8, 8'h00, 9'h000, 4, 8'h01);
        hard_threshold_select = 1;
        glitch_filter_time = 2'h3;
        pk = 9'h0C9;
        wait_gate;
        chk({7'h0, k > 199 && k < 210}, 8'h01);
        tick(2);
        chk({6'h0, hold_active, shutdown_latched}, 8'h01);
        go(12'h3E8, 8'h00, 9'h000, 8, 8'hC5);
        clr;
        go(12'h3E8, 8'h00, 9'h000, 2, 8'h01);
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
